/* File: core/sbc_irq_encoder.sv */
/*
 * Event and interrupt register block with its serial slave.
 * Assumes detector inputs are one-cycle pulses on sys_clk, the serial pins
 * and wake pin are asynchronous, and the link clock is far below sys_clk.
 */
`timescale 1ns/1ps
module sbc_irq_encoder
	import sbc_irq_pkg::*;
(
	// Clock and reset
	input  wire logic             sys_clk,
	input  wire logic             rstn,
	// Serial pins
	input  wire spi_in_t          spiPins,
	output logic                  sdo_q,
	output logic                  sdoOe_q,
	// Detectors and status
	input  wire det_ev_t          detEv,
	input  wire logic             wakePin,
	input  wire logic [1:0]       tcvrCode,
	input  wire logic             devModeActive,
	input  wire logic             modeRejected,
	// Interrupt request, active low
	output logic                  intReqN_q
);

	////////////////////////////////////////////////////////////////////
	// Input synchronisers (two flops before any use)
	logic [3:0] syncA_q;        // First stage, read only by stage two
	logic [3:0] syncB_q;        // Stable copies
	logic [3:0] syncC_q;        // History for edge detect

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			syncA_q <= 4'hF;
			syncB_q <= 4'hF;
			syncC_q <= 4'hF;
		end else begin
			syncA_q <= {wakePin, spiPins.csN, spiPins.sck, spiPins.sdi};
			syncB_q <= syncA_q;
			syncC_q <= syncB_q;
		end
	end

	logic csN, sdiS, sckRise, sckFall, csFall, csRise, wkRise, wkFall;
	assign csN     = syncB_q[2];
	assign sdiS    = syncB_q[0];
	assign sckRise = syncB_q[1] & ~syncC_q[1];
	assign sckFall = ~syncB_q[1] & syncC_q[1];
	assign csFall  = ~syncB_q[2] & syncC_q[2];
	assign csRise  = syncB_q[2] & ~syncC_q[2];
	assign wkRise  = syncB_q[3] & ~syncC_q[3];
	assign wkFall  = ~syncB_q[3] & syncC_q[3];

	////////////////////////////////////////////////////////////////////
	// Registers
	logic [2:0] wakeEn_q;       // Bus wake, pin fall, pin rise
	logic [8:0] failEn_q;       // Failure register enables
	logic       linkEn_q;       // Bus failure enable
	logic [3:0] wakeFl_q;       // Cyc, rise, fall, bus flags
	logic [8:0] failFl_q;       // Failure flags
	logic       linkFl_q;       // Bus failure flag
	logic       spiErr;         // Rejected frame pulse
	logic       rdWake, rdFail, rdLink;  // Frame-end read strobes
	logic [15:0] rxSh_q;        // Received shift register
	logic [4:0]  bitCnt_q;      // Falling edges seen
	logic [15:0] txSh_q;        // Outgoing shift register
	logic [15:0] lastOut_q;     // Answer kept for repeat on error
	logic        errPend_q;     // Announce error in next frame
	logic        sumFlag;       // Anything pending in the failure registers

	// Summary: a live fault code counts as a status bit
	assign sumFlag = |failFl_q | linkFl_q | (tcvrCode != TC_NONE); // [RULE6]

	// Output word of one register
	function automatic logic [8:0] regOut(input logic [2:0] sel);
		case (sel)
			SEL_WAKE: regOut = {4'h0, sumFlag, wakeFl_q};   // [RULE6] [RULE21]
			SEL_FAIL: regOut = failFl_q;
			SEL_LINK: regOut = {6'h00, tcvrCode, linkFl_q};   // [RULE16]
			default:  regOut = 9'h000;
		endcase
	endfunction : regOut

	////////////////////////////////////////////////////////////////////
	// Frame receive and validity check
	logic [2:0] rxMode, rxSel;
	logic       frameEnd, frameOk, doWrite;
	assign rxMode   = rxSh_q[MODE_HI:MODE_LO];
	assign rxSel    = rxSh_q[SEL_HI:SEL_LO];
	assign frameEnd = csRise;
	// Bit count must be 16, mode 000 invalid, illegal mode request invalid
	assign frameOk  = (bitCnt_q == 5'h10) && (rxMode != MODE_BAD)
		&& !modeRejected;
	assign spiErr   = frameEnd && !frameOk;                  // [RULE18]
	assign doWrite  = frameEnd && frameOk && (rxMode != MODE_READ); // [RULE19]
	assign rdWake   = frameEnd && frameOk && rxSel == SEL_WAKE;
	assign rdFail   = frameEnd && frameOk && rxSel == SEL_FAIL;
	assign rdLink   = frameEnd && frameOk && rxSel == SEL_LINK;

	// Sample data on clock falling edges while selected
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			rxSh_q   <= 16'h0000;
			bitCnt_q <= 5'h00;
		end else if (csFall) begin
			bitCnt_q <= 5'h00;
		end else if (!csN && sckFall) begin
			rxSh_q   <= {rxSh_q[14:0], sdiS};
			bitCnt_q <= (bitCnt_q == 5'h1F) ? bitCnt_q : bitCnt_q + 5'h01;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Enable writes; a zero written clears, a one sets
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			wakeEn_q <= WAKE_EN_RST;                         // [RULE2]
			failEn_q <= FAIL_EN_RST;                         // [RULE2]
			linkEn_q <= LINK_EN_RST;                         // [RULE2]
		end else if (doWrite) begin
			case (rxSel)
				SEL_WAKE: wakeEn_q <= rxSh_q[2:0];           // [RULE3] [RULE17]
				SEL_FAIL: failEn_q <= rxSh_q[8:0];           // [RULE3] [RULE17]
				SEL_LINK: linkEn_q <= rxSh_q[L_BUS];         // [RULE3] [RULE17]
				default:  linkEn_q <= linkEn_q;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Event flags; a new event wins over the read clear
	logic [3:0] wakeSet;
	logic [8:0] failSet;
	assign wakeSet = {detEv.periodicWake,                      // [RULE21]
		wkRise & wakeEn_q[WK_HI], wkFall & wakeEn_q[WK_LO],    // [RULE5]
		detEv.busWake & wakeEn_q[WK_BUS]};                     // [RULE4]
	assign failSet = {detEv.supply3Oc, detEv.supply2Uv,        // [RULE14] [RULE13]
		detEv.badWatchdog,                                     // [RULE12]
		detEv.resetSeen & devModeActive,                       // [RULE11]
		spiErr,                                                // [RULE10]
		detEv.supply3Uv,                                       // [RULE9]
		detEv.supply2Hot, detEv.tcvrHot,                       // [RULE8]
		detEv.mcuHeat} & failEn_q;                             // [RULE7]

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			wakeFl_q <= 4'h0;
			failFl_q <= FLAG_RST;
			linkFl_q <= 1'b0;
		end else begin
			wakeFl_q <= (rdWake ? 4'h0 : wakeFl_q) | wakeSet;   // [RULE20]
			failFl_q <= (rdFail ? 9'h000 : failFl_q) | failSet; // [RULE20]
			linkFl_q <= (rdLink ? 1'b0 : linkFl_q)
				| (detEv.busFail & linkEn_q);                   // [RULE15]
		end
	end

	// Request low while any enabled flag stays unread
	always_ff @(posedge sys_clk) begin
		if (!rstn) intReqN_q <= 1'b1;
		else intReqN_q <= ~(|wakeFl_q | |failFl_q | linkFl_q); // [RULE1] [RULE20]
	end

	////////////////////////////////////////////////////////////////////
	// Serial output: error bit first, then last answer, shifted on rise
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			txSh_q    <= 16'h0000;
			lastOut_q <= 16'h0000;
			errPend_q <= 1'b0;
			sdo_q     <= 1'b0;
			sdoOe_q   <= 1'b0;
		end else begin
			if (frameEnd) begin
				errPend_q <= !frameOk;                           // [RULE18]
				if (frameOk)
					lastOut_q <= {1'b0, rxMode, rxSel, regOut(rxSel)};
			end
			if (csFall) begin
				txSh_q  <= lastOut_q;
				sdo_q   <= errPend_q;
				sdoOe_q <= 1'b1;
			end else if (!csN && sckFall && bitCnt_q == 5'h06
				&& rxSh_q[4:2] == MODE_READ) begin
				// Select completes on the seventh bit; its content
				// fills the last nine output bits of this frame
				txSh_q <= {regOut({rxSh_q[1:0], sdiS}), 7'h00}; // [RULE19]
			end else if (!csN && sckRise) begin
				sdo_q  <= txSh_q[15];
				txSh_q <= {txSh_q[14:0], 1'b0};
			end else if (csN) begin
				sdoOe_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Checks
	chk_pin_held: assert property (@(posedge sys_clk) disable iff (!rstn)
		(failFl_q != 9'h000 && !rdFail) |=> !intReqN_q) // [RULE1]
		else $error("interrupt pin released with flags pending");
	chk_reset_en: assert property (@(posedge sys_clk)
		!rstn |=> failEn_q == 9'h1FF && wakeEn_q == 3'h7) // [RULE2]
		else $error("enables not set after reset");
	chk_mask_src: assert property (@(posedge sys_clk) disable iff (!rstn)
		(!failEn_q[F_HEAT] && !failFl_q[F_HEAT]) |=> !failFl_q[F_HEAT]) // [RULE3]
		else $error("masked source raised a flag");
	chk_spi_err: assert property (@(posedge sys_clk) disable iff (!rstn)
		(spiErr && failEn_q[F_SPI]) |=> failFl_q[F_SPI] ##1 !intReqN_q) // [RULE18]
		else $error("serial error not flagged");
	chk_ro_nowr: assert property (@(posedge sys_clk) disable iff (!rstn)
		(frameEnd && rxMode == MODE_READ) |=> $stable(failEn_q) && $stable(wakeEn_q)) // [RULE19]
		else $error("read-only frame wrote a register");
	chk_rd_clear: assert property (@(posedge sys_clk) disable iff (!rstn)
		(rdLink && !detEv.busFail) |=> !linkFl_q) // [RULE20]
		else $error("read did not clear flag");
	chk_rst_mode: assert property (@(posedge sys_clk) disable iff (!rstn)
		(!devModeActive && !failFl_q[F_RST]) |=> !failFl_q[F_RST]) // [RULE11]
		else $error("reset flag outside development mode");
	chk_summary: assert property (@(posedge sys_clk) disable iff (!rstn)
		linkFl_q |-> sumFlag) // [RULE6]
		else $error("summary flag missing");
	chk_uv_both: assert property (@(posedge sys_clk) disable iff (!rstn)
		(detEv.supply3Uv && failEn_q[F_S3UV]) |=> failFl_q[F_S3UV]) // [RULE9]
		else $error("undervoltage event lost");
	cov_read_ro: cover property (@(posedge sys_clk) frameEnd && rxMode == MODE_READ);
	cov_spi_err: cover property (@(posedge sys_clk) spiErr);
	cov_irq_rel: cover property (@(posedge sys_clk) $rose(intReqN_q));

endmodule : sbc_irq_encoder

/* File: inc/sbc_irq_pkg.sv */
/*
 * Constants, field layouts and frame types of the event/interrupt encoder.
 * Assumes a 16-bit host frame: [15] watchdog bit, [14:12] mode select,
 * [11:9] register select, [8:0] register data (input or output side).
 */
// What this block does
// (RULE1) Interrupt pin held until matching register read
// (RULE2) All enables set after reset
// (RULE3) Each source except periodic wake has its own enable bit
// (RULE4) Wake register holds bus wake enable/flag
// (RULE5) Pin wake field codes rise=10, fall=01
// (RULE6) Summary flag reflects failure registers pending
// (RULE7) Supply heat warning enable and flag
// (RULE8) Transceiver and second supply thermal shutdown
// (RULE9) Third supply undervoltage fires both directions
// (RULE10) Corrupted serial frame enable and flag
// (RULE11) Reset flag active only in development mode
// (RULE12) Bad watchdog setting enable and flag
// (RULE13) Second supply undervoltage enable and flag
// (RULE14) Third supply overcurrent enable and flag
// (RULE15) Bus failure enable and flag
// (RULE16) Transceiver fault code 00/01/10/11 reported
// (RULE17) Written zero selects the opposite state
// (RULE18) Rejected frame sets serial error flag
// (RULE19) Mode 111 reads register, writes nothing
// (RULE20) Read clears flags, pin released when idle
// (RULE21) Periodic wake flag, output only
package sbc_irq_pkg;
	// Frame layout
	localparam int FRAME_W   = 16;
	localparam int MODE_HI   = 14;
	localparam int MODE_LO   = 12;
	localparam int SEL_HI    = 11;
	localparam int SEL_LO    = 9;
	localparam int DATA_W    = 9;
	// Register selects
	localparam logic [2:0] SEL_WAKE = 3'h0;
	localparam logic [2:0] SEL_FAIL = 3'h1;
	localparam logic [2:0] SEL_LINK = 3'h2;
	// Mode codes
	localparam logic [2:0] MODE_BAD  = 3'h0;
	localparam logic [2:0] MODE_READ = 3'h7;
	// Enable reset values, output reset value
	localparam logic [2:0] WAKE_EN_RST = 3'h7;
	localparam logic [8:0] FAIL_EN_RST = 9'h1FF;
	localparam logic       LINK_EN_RST = 1'h1;
	localparam logic [8:0] FLAG_RST    = 9'h000;
	// Wake field bit positions
	localparam int WK_BUS = 0;
	localparam int WK_LO  = 1;
	localparam int WK_HI  = 2;
	localparam int WK_CYC = 3;
	localparam int WK_SUM = 4;
	// Failure field bit positions
	localparam int F_HEAT = 0;
	localparam int F_TCVR = 1;
	localparam int F_S2OT = 2;
	localparam int F_S3UV = 3;
	localparam int F_SPI  = 4;
	localparam int F_RST  = 5;
	localparam int F_WDOG = 6;
	localparam int F_S2UV = 7;
	localparam int F_S3OC = 8;
	// Link field bit positions
	localparam int L_BUS  = 0;
	localparam int L_CODE = 1;
	// Fault codes
	localparam logic [1:0] TC_NONE  = 2'h0;
	localparam logic [1:0] TC_TXGND = 2'h1;
	localparam logic [1:0] TC_RXVCC = 2'h2;
	localparam logic [1:0] TC_TXRX  = 2'h3;

	// Detector event pulses, grouped
	typedef struct packed {
		logic busWake;
		logic periodicWake;
		logic mcuHeat;
		logic tcvrHot;
		logic supply2Hot;
		logic supply3Uv;
		logic resetSeen;
		logic badWatchdog;
		logic supply2Uv;
		logic supply3Oc;
		logic busFail;
	} det_ev_t;

	// Serial pins from the host
	typedef struct packed {
		logic csN;
		logic sck;
		logic sdi;
	} spi_in_t;
endpackage : sbc_irq_pkg

/* File: tb/sbc_host_model.sv */
/*
 * Host serial master model for the event encoder.
 * Assumes the device samples these pins with its own clock; link clock
 * period 64 ns, idle low, running only inside frames.
 */
`timescale 1ns/1ps
module sbc_host_model
	import sbc_irq_pkg::*;
(
	// Serial pins
	output spi_in_t    pins,
	input  wire logic  sdo,
	input  wire logic  sdoOe
);
	// Deselected, clock still
	initial pins = '{csN: 1'b1, sck: 1'b0, sdi: 1'b1};

	////////////////////////////////////////////////////////////////////////
	// One frame, MSB first; e is the bit shown before the first rise
	task automatic xfer(input logic [15:0] w, input int nb,
		output logic [15:0] r, output logic e);
		r = 16'h0000;
		#16 pins.csN = 1'b0;
		#32 e = sdoOe ? sdo : 1'bx;
		for (int i = 0; i < nb; i++) begin
			// Data moves mid-low so it is steady at the falling edge
			#16 pins.sdi = w[15 - i];
			#16 pins.sck = 1'b1;
			#32 pins.sck = 1'b0;
			r = {r[14:0], sdo};
		end
		#32 pins.csN = 1'b1;
		// Released line, no pull: show the inverse
		pins.sdi = ~pins.sdi;
		#64;
	endtask : xfer
endmodule : sbc_host_model

/* File: tb/sbc_interrupt_status_encoder_tb_top.sv */
/*
 * Self-checking bench of the event encoder with a host model.
 * Assumes detector inputs are one-cycle pulses; mode requests are legal except in one frame driven with a refused mode.
 */
`timescale 1ns/1ps
module sbc_interrupt_status_encoder_tb_top import sbc_irq_pkg::*;;
	logic        sys_clk = 1'b0;
	logic        rstn = 1'b0;
	logic [10:0] evBits = '0;   // Detector pulses, busWake on top
	logic        wakePin = 1'b1; // Idle high matches synchroniser reset
	logic        devModeActive = 1'b1;
	logic        modeRej = 1'b0; // Illegal mode request at frame end
	logic [1:0]  tcvrCode = 2'h0;
	spi_in_t     spiPins;
	logic        sdo_q, sdoOe_q, intReqN_q, er;
	logic [15:0] rx, prev;
	int          mismatches = 0, n_compared = 0;
	// Ordinary cases: event bit, register, flag position
	typedef struct {int ev; logic [2:0] sel; int pos;} row_t;
	row_t rows[11] = '{'{10, SEL_WAKE, WK_BUS}, '{9, SEL_WAKE, WK_CYC},
		'{8, SEL_FAIL, F_HEAT}, '{7, SEL_FAIL, F_TCVR},
		'{6, SEL_FAIL, F_S2OT}, '{5, SEL_FAIL, F_S3UV},
		'{4, SEL_FAIL, F_RST}, '{3, SEL_FAIL, F_WDOG},
		'{2, SEL_FAIL, F_S2UV}, '{1, SEL_FAIL, F_S3OC},
		'{0, SEL_LINK, L_BUS}};

	always #2.5 sys_clk = ~sys_clk;

	sbc_irq_encoder u_dut(.sys_clk(sys_clk), .rstn(rstn), .spiPins(spiPins),
		.sdo_q(sdo_q), .sdoOe_q(sdoOe_q), .detEv(det_ev_t'(evBits)),
		.wakePin(wakePin), .tcvrCode(tcvrCode),
		.devModeActive(devModeActive), .modeRejected(modeRej),
		.intReqN_q(intReqN_q));
	sbc_host_model u_host(.pins(spiPins), .sdo(sdo_q), .sdoOe(sdoOe_q));

	////////////////////////////////////////////////////////////////////////
	task automatic cmp(input logic [15:0] g, input logic [15:0] x);
		n_compared++;
		if (g !== x) begin
			mismatches++;
			$display("unexpected at %0t: got %h want %h", $time, g, x);
		end
	endtask : cmp

	// Read-only frame: low nine answer bits carry the register now
	task automatic rd(input logic [2:0] s, input logic [8:0] x);
		u_host.xfer({4'h7, s, 9'h000}, 16, rx, er);
		cmp({7'h00, rx[8:0]}, {7'h00, x});
	endtask : rd

	task automatic pulse(input int i);
		@(posedge sys_clk) evBits[i] <= 1'b1;
		@(posedge sys_clk) evBits <= '0;
	endtask : pulse

	// Bounded wait for the request pin level
	task automatic waitInt(input logic v);
		for (int k = 0; k < 80 && intReqN_q !== v; k++)
			@(posedge sys_clk);
		cmp({15'h0, intReqN_q}, {15'h0, v});
	endtask : waitInt

	task automatic wrap_up;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : wrap_up

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (16) @(posedge sys_clk);
		rstn <= 1'b1;
		repeat (8) @(posedge sys_clk);
		cmp({14'h0, intReqN_q, sdoOe_q}, 16'h0002);
		// Every detector source raises and clears through a read-only access
		foreach (rows[i]) begin
			pulse(rows[i].ev);
			waitInt(1'b0);
			rd(rows[i].sel, 9'(1 << rows[i].pos));
			waitInt(1'b1);
		end
		// One source masked, a neighbour still fires
		u_host.xfer({4'h3, SEL_FAIL, 9'h1FE}, 16, rx, er);
		pulse(8);
		repeat (20) @(posedge sys_clk);
		cmp({15'h0, intReqN_q}, 16'h0001);
		pulse(7);
		waitInt(1'b0);
		u_host.xfer({4'h3, SEL_FAIL, 9'h1FF}, 16, rx, er);
		waitInt(1'b1);
		// Summary bit; the wake read leaves the pin low
		pulse(2);
		rd(SEL_WAKE, 9'h010);
		waitInt(1'b0);
		rd(SEL_FAIL, 9'h080);
		// Wake pin edges
		@(posedge sys_clk) wakePin <= 1'b0;
		rd(SEL_WAKE, 9'h002);
		@(posedge sys_clk) wakePin <= 1'b1;
		rd(SEL_WAKE, 9'h004);
		@(posedge sys_clk) wakePin <= 1'b0;
		repeat (10) @(posedge sys_clk);
		wakePin <= 1'b1;
		rd(SEL_WAKE, 9'h006);
		// Transceiver fault codes
		for (int c = 0; c < 4; c++) begin
			@(posedge sys_clk) tcvrCode <= 2'(c);
			rd(SEL_LINK, {6'h00, 2'(c), 1'b0});
		end
		@(posedge sys_clk) tcvrCode <= 2'h0;
		prev = {4'h7, SEL_LINK, 9'h000};
		// Short frame, mode 000, refused mode: flagged, header repeats
		for (int k = 0; k < 3; k++) begin
			@(posedge sys_clk) modeRej <= (k == 2);
			u_host.xfer((k == 0) ? {4'h7, SEL_WAKE, 9'h000} :
				(k == 1) ? {4'h0, SEL_WAKE, 9'h000} :
				{4'h3, SEL_WAKE, 9'h000}, (k == 0) ? 12 : 16, rx, er);
			@(posedge sys_clk) modeRej <= 1'b0;
			waitInt(1'b0);
			u_host.xfer({4'h7, SEL_FAIL, 9'h000}, 16, rx, er);
			cmp({15'h0, er}, 16'h0001);
			cmp({9'h000, rx[15:9]}, {9'h000, prev[15:9]});
			cmp({7'h00, rx[8:0]}, 16'h0010);
			prev = {4'h7, SEL_FAIL, 9'h000};
		end
		// The refused write left the bus wake enable set
		pulse(10);
		rd(SEL_WAKE, 9'h001);
		// Reset source outside development mode
		@(posedge sys_clk) devModeActive <= 1'b0;
		pulse(4);
		repeat (20) @(posedge sys_clk);
		cmp({15'h0, intReqN_q}, 16'h0001);
		devModeActive <= 1'b1;
		rd(SEL_FAIL, 9'h000);
		// Mid-run reset brings the cleared heat warning enable back
		u_host.xfer({4'h3, SEL_FAIL, 9'h000}, 16, rx, er);
		@(posedge sys_clk) rstn <= 1'b0;
		repeat (16) @(posedge sys_clk);
		rstn <= 1'b1;
		repeat (8) @(posedge sys_clk);
		pulse(8);
		waitInt(1'b0);
		rd(SEL_FAIL, 9'h001);
		wrap_up();
	end
endmodule : sbc_interrupt_status_encoder_tb_top
